//--- hdl/sadc_pkg.sv
// Constants and carriers for the serial converter readout block
package sadc_pkg;
  localparam int          SADC_CLK_MHZ    = 50;
  localparam int          SADC_CONV_NS    = 8500;
  localparam int          SADC_CONV_CYC   = (SADC_CONV_NS * SADC_CLK_MHZ) / 1000;
  localparam int          SADC_BITS       = 12;
  localparam logic [11:0] SADC_RESULT_RST = 12'h000;
  localparam logic [3:0]  SADC_CNT_RST    = 4'h0;

  // Three-level power-down pin decoded
  typedef enum logic [1:0] {SADC_PD_SHUTDOWN, SADC_PD_EXT_REF, SADC_PD_INT_REF} sadc_pd_e;

  // Conversion phase
  typedef enum logic [1:0] {SADC_IDLE, SADC_CONVERT, SADC_DONE} sadc_state_e;

  // Status handed across to the link domain
  typedef struct packed {
    logic        done;
    logic [11:0] result;
  } sadc_result_s;
endpackage

//--- hdl/sadc_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sadc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,   // Destination clock
  input  wire logic             rst_i,   // Async reset, high
  input  wire logic [WIDTH-1:0] d_i,     // Foreign level
  output logic      [WIDTH-1:0] q_o      // Synchronised level
);
  logic [WIDTH-1:0] meta;

  // First stage read only by second stage
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule
`default_nettype wire

//--- hdl/sadc_core.sv
// Conversion timer and serial readout of the converter
`timescale 1ns/1ns
`default_nettype none
module sadc_core
  import sadc_pkg::*;
#(
  parameter int BITS = SADC_BITS
) (
  input  wire logic             clock_i,        // 50 MHz core clock
  input  wire logic             rst_i,          // Async reset, high
  input  wire logic             sclk_i,         // Serial clock, link domain
  input  wire logic             select_n_i,     // Active-low select pin
  input  wire logic             power_down_n_i, // Pin driven level
  input  wire logic             power_down_oe_i,// Pin driven (else floating)
  input  wire logic [BITS-1:0]  sample_i,       // Digitised input value
  output logic                  dout_o,         // Serial data out
  output logic                  dout_oe_o,      // Serial data drive enable
  output logic                  tracking_o,     // Sampler tracking input
  output logic                  int_ref_en_o,   // Internal reference on
  output logic                  shutdown_o      // Converter shut down
);
  // Only the 12-bit frame is served by the shift logic
  if (BITS != SADC_BITS) begin : g_bits_chk
    $error("BITS must equal 12");
  end

  logic [1:0]   pins_s;
  logic         sel_s;
  logic         sel_n_s;
  logic         sel_n_d;
  logic         pd_lvl_s;
  logic         pd_oe_s;
  sadc_pd_e     pd_mode;
  sadc_state_e  state;
  logic [13:0]  timer;
  sadc_result_s res;
  logic [BITS-1:0] held;

  sadc_sync #(.WIDTH(2)) u_pin_sync (
    .clk_i (clock_i),
    .rst_i (rst_i),
    .d_i   ({power_down_n_i, power_down_oe_i}),
    .q_o   (pins_s)
  );
  assign pd_lvl_s = pins_s[1];
  assign pd_oe_s  = pins_s[0];

  sadc_sync #(.WIDTH(1)) u_sel_sync (
    .clk_i (clock_i),
    .rst_i (rst_i),
    .d_i   (~select_n_i),
    .q_o   (sel_s)
  );
  // Synchronised as active high so reset reads as deselected, no false edge
  assign sel_n_s = !sel_s;

  // Three-level power-down decode
  always_comb begin
    if (!pd_oe_s)      pd_mode = SADC_PD_EXT_REF;
    else if (pd_lvl_s) pd_mode = SADC_PD_INT_REF;
    else               pd_mode = SADC_PD_SHUTDOWN;
  end
  assign int_ref_en_o = (pd_mode == SADC_PD_INT_REF);
  assign shutdown_o   = (pd_mode == SADC_PD_SHUTDOWN);

  // Select delay for edge detect
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) sel_n_d <= 1'b1;
    else       sel_n_d <= sel_n_s;
  end

  // Conversion sequencer
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= SADC_IDLE;
      timer <= '0;
      held  <= SADC_RESULT_RST;
    end else if (sel_n_s || shutdown_o) begin
      state <= SADC_IDLE;                         // Abort on deselect or shutdown
      timer <= '0;
    end else begin
      case (state)
        SADC_IDLE: begin
          if (sel_n_d) begin                      // Falling edge only
            state <= SADC_CONVERT;
            held  <= sample_i;                    // Freeze sample
            timer <= '0;
          end
        end
        SADC_CONVERT: begin
          if (timer == 14'(SADC_CONV_CYC - 1)) begin
            state <= SADC_DONE;
          end else begin
            timer <= timer + 14'h1;
          end
        end
        SADC_DONE: state <= SADC_DONE;            // Wait for deselect
        default:   state <= SADC_IDLE;
      endcase
    end
  end

  assign tracking_o = (state != SADC_CONVERT);

  // Result and done flag to link domain
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      res <= '{done: 1'b0, result: SADC_RESULT_RST};
    end else begin
      res.done   <= (state == SADC_DONE);
      res.result <= held;
    end
  end

  // Link domain: done and result are quasi-static registers here.
  // The host keeps sclk idle until the flag shows, so both have settled
  // long before the first falling edge that reads them.
  logic [3:0]   cnt;
  logic [11:0]  shreg;
  logic         link_bit;

  // Shift on falling edges, reset by select high
  always_ff @(negedge sclk_i or posedge select_n_i) begin
    if (select_n_i) begin
      cnt      <= SADC_CNT_RST;
      shreg    <= SADC_RESULT_RST;
      link_bit <= 1'b0;
    end else if (res.done) begin                  // First fall after flag
      if (cnt == SADC_CNT_RST) begin
        link_bit <= res.result[11];               // MSB first
        shreg    <= {res.result[10:0], 1'b0};
        cnt      <= 4'h1;
      end else begin
        link_bit <= shreg[11];                    // Zeros after LSB
        shreg    <= {shreg[10:0], 1'b0};
        if (cnt != 4'hf) cnt <= cnt + 4'h1;
      end
    end
  end

  // Before first falling edge, output shows done flag directly
  assign dout_o    = (cnt == SADC_CNT_RST) ? res.done : link_bit;
  assign dout_oe_o = !select_n_i;

  // Checks
  conv_len_a: assert property (@(posedge clock_i) disable iff (rst_i)
    $rose(state == SADC_CONVERT) |-> (state == SADC_CONVERT) [*8] ##[1:430] (state == SADC_DONE || sel_n_s))
    else $error("conversion length wrong");
  no_restart_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SADC_DONE && !sel_n_s) |=> state == SADC_DONE)
    else $error("conversion restarted without select");
  track_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SADC_DONE) |-> tracking_o)
    else $error("sampler not tracking after conversion");
  hiz_a: assert property (@(posedge clock_i) disable iff (rst_i)
    select_n_i |-> !dout_oe_o)
    else $error("output driven while deselected");
  low_conv_a: assert property (@(posedge clock_i) disable iff (rst_i)
    (state == SADC_CONVERT && !res.done) |-> !dout_o)
    else $error("output not low during conversion");
  ref_mode_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !(int_ref_en_o && shutdown_o))
    else $error("power mode decode conflict");
  start_cv: cover property (@(posedge clock_i) disable iff (rst_i) $rose(state == SADC_CONVERT));
  done_cv:  cover property (@(posedge clock_i) disable iff (rst_i) $rose(state == SADC_DONE));
  abort_cv: cover property (@(posedge clock_i) disable iff (rst_i) state == SADC_CONVERT ##1 state == SADC_IDLE);
endmodule
`default_nettype wire

//--- bench/sadc_host.sv
// Host side serial clock source for the converter readout
`timescale 1ns/1ns
`default_nettype none
module sadc_host (
  input  wire logic run_i,  // Clock bursts while high
  output logic      sclk_o  // Serial clock, idle low
);
  // Burst clock, stands still low outside frames
  initial sclk_o = 1'b0;
  always begin
    wait (run_i);
    #62 sclk_o = run_i; // Phases 62/63 ns, 8 MHz bench burst
    #63 sclk_o = 1'b0;
  end
endmodule
`default_nettype wire

//--- bench/test_serial_adc_conversion_readout.sv
// Self-checking bench for the converter readout block
`timescale 1ns/1ns
`default_nettype none
module test_serial_adc_conversion_readout;
  import sadc_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, sel_n = 1'b1, pd_n = 1'b1, pd_oe = 1'b1, run = 1'b0;
  logic [11:0] sample = 12'h000;
  wire         sclk, dout, dout_oe, tracking, int_ref, shutdown;
  int          fails = 0, checks = 0, cyc = 0;

  sadc_host u_host (.run_i(run), .sclk_o(sclk));
  sadc_core u_dut (.clock_i(clk), .rst_i(rst), .sclk_i(sclk), .select_n_i(sel_n),
    .power_down_n_i(pd_n), .power_down_oe_i(pd_oe), .sample_i(sample), .dout_o(dout),
    .dout_oe_o(dout_oe), .tracking_o(tracking), .int_ref_en_o(int_ref), .shutdown_o(shutdown));

  // Core clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      end_of_test();
    end
  end

  // Compare and report
  task check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Full conversion, readout with trailing zeros, held select
  task conv_read(input logic [11:0] val);
    int n;
    n = 0;
    @(negedge clk) sample = val;
    sel_n = 1'b0;
    repeat (3) @(negedge clk);
    check(dout_oe, 12'h001);
    check(dout, 12'h000);
    check(tracking, 12'h000);
    sample = ~val;
    while (dout !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    check(n >= 420 && n <= 440, 12'h001);
    @(negedge clk) run = 1'b1;
    for (int i = 0; i < 14; i++) begin // 14 falls, at least 13
      @(negedge sclk);
      #30;
      check(dout, (i < 12) ? val[11-i] : 12'h000);
    end
    @(negedge clk) run = 1'b0;
    repeat (500) @(negedge clk);
    check(dout, 12'h000);
    check(tracking, 12'h001);
    sel_n = 1'b1;
    @(posedge clk);
    check(dout_oe, 12'h000);
    repeat (75) @(negedge clk);
  endtask

  // Conversion cut short by select, then a clean restart
  task abort_run;
    @(negedge clk) sel_n = 1'b0;
    repeat (100) @(negedge clk);
    check(dout, 12'h000);
    sel_n = 1'b1;
    repeat (5) @(negedge clk);
    check(dout_oe, 12'h000);
    repeat (75) @(negedge clk);
    conv_read(12'h001);
  endtask

  // Three pin levels, then a start refused in shutdown
  task power_modes;
    logic [1:0] oe_lvl [3];
    logic [1:0] expect_mode [3];
    oe_lvl = '{2'h3, 2'h0, 2'h2};
    expect_mode = '{2'h2, 2'h0, 2'h1};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk) {pd_oe, pd_n} = oe_lvl[i];
      repeat (4) @(negedge clk);
      check({int_ref, shutdown}, expect_mode[i]);
    end
    sel_n = 1'b0;
    repeat (600) @(negedge clk);
    check(dout, 12'h000);
    sel_n = 1'b1;
    {pd_oe, pd_n} = 2'h3;
    repeat (100) @(negedge clk);
    conv_read(12'h800);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk); // Reference charge taken as done
    conv_read(12'ha5c);
    conv_read(12'hfff);
    abort_run();
    power_modes();
    end_of_test();
  end
endmodule
`default_nettype wire
